/* File: design/power_mode_defs.vh */
// Operation
// - Push-to-fix sleeps at most two hours, then wakes to refresh data.
// - Toggle rise hibernates a running receiver and wakes a sleeping one.
// - Text-mode shutdown sentence with parameter 16 enters the off state after wind-down.
// - Binary message 205 enters the software-commanded off state.
// - After commanded off, clock and memory run from the backup supply.
`ifndef POWER_MODE_DEFS_VH
`define POWER_MODE_DEFS_VH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define MCLK_HZ 40'h0007735940
`define PTF_SLEEP_MAX_S 40'h0000001C20
`define PTF_CNT_W 40
`define HOST_SUPPLY_HOLD_MS 32'h000007D0
`define WIND_DOWN_MS 32'h0000000A
`define MS_PER_S 40'h00000003E8
`define CNT_ONE 40'h0000000001
`define CNT_ZERO 40'h0000000000

// ==========================================================================
// Firmware feature thresholds, major/minor/patch in nibbles
// ==========================================================================
`define FW_VER_W 12
`define FW_TOGGLE_MIN 12'h325
`define FW_SHUTDOWN_MIN 12'h350
`define FW_DEFAULT 12'h350

// ==========================================================================
// Command decode
// ==========================================================================
`define CMD_W 8
`define NMEA_SHUTDOWN_PARAM 8'h10
`define BIN_OFF_MSG_ID 8'hCD

// ==========================================================================
// Mode state encoding width
// ==========================================================================
`define MODE_W 3

`endif

/* File: design/pin_sync3.v */
`timescale 1ns/1ps
// ==========================================================================
// Three-stage pin synchroniser with agreement filter
// ==========================================================================
module pin_sync3
(
    input wire mclk,
    input wire rst,
    input wire pin,
    output reg level_q
);

reg s1_q;
reg s2_q;
reg s3_q;

always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        level_q <= 1'b0;
    end
    else
    begin
        s1_q <= pin;
        s2_q <= s1_q;
        s3_q <= s2_q;
        // Stage one stays out of the compare; it may be metastable
        if (s2_q == s3_q)
        begin
            level_q <= s3_q;
        end
    end
end

endmodule // pin_sync3

/* File: design/power_mode_ctrl.v */
`timescale 1ns/1ps
`include "power_mode_defs.vh"

// ==========================================================================
// Receiver power-mode controller
// ==========================================================================
module power_mode_ctrl
#(
    // Firmware level the core reports; arbitrary default
    parameter [11:0] FW_VERSION = `FW_DEFAULT,
    // Longest push-to-fix sleep, two hours of mclk
    parameter [39:0] PTF_SLEEP_CYCLES = `PTF_SLEEP_MAX_S * `MCLK_HZ,
    // Wind-down before the RF indicator drops after a shutdown command
    parameter [39:0] WIND_DOWN_CYCLES =
        (`WIND_DOWN_MS * `MCLK_HZ) / `MS_PER_S
)
(
    input wire mclk,
    input wire rst,
    input wire power_toggle,
    input wire ptf_enable,
    input wire fix_done,
    input wire cmd_valid,
    input wire cmd_binary_mode,
    input wire cmd_is_shutdown_sentence,
    input wire [7:0] cmd_msg_id,
    input wire [7:0] cmd_param,
    output reg rf_power_up_indicator,
    output reg core_power_en,
    output reg refresh_req,
    output reg rtc_run,
    output reg sram_retain,
    output reg backup_supply_select,
    output reg cmd_accept,
    output reg [2:0] mode
);

// ==========================================================================
// States
// ==========================================================================
localparam [2:0] ST_RUN = 3'h0;
localparam [2:0] ST_PTF_SLEEP = 3'h1;
localparam [2:0] ST_HIBERNATE = 3'h2;
localparam [2:0] ST_WIND_DOWN = 3'h3;
localparam [2:0] ST_OFF = 3'h4;

// ==========================================================================
// Toggle pin synchronisation and edge detect
// ==========================================================================
wire toggle_level;
reg toggle_prev_q;
wire toggle_rise;

pin_sync3 u_toggle_sync
(
    .mclk(mclk),
    .rst(rst),
    .pin(power_toggle),
    .level_q(toggle_level)
);

always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        toggle_prev_q <= 1'b0;
    end
    else
    begin
        toggle_prev_q <= toggle_level;
    end
end

// One edge per pulse; holding the pin high does nothing more
assign toggle_rise = toggle_level & ~toggle_prev_q;

// ==========================================================================
// Feature gating by firmware level
// ==========================================================================
wire toggle_hib_ok;
wire nmea_off_ok;

assign toggle_hib_ok = (FW_VERSION >= `FW_TOGGLE_MIN);
assign nmea_off_ok = (FW_VERSION >= `FW_SHUTDOWN_MIN);

// ==========================================================================
// Shutdown command decode
// ==========================================================================
wire nmea_shutdown;
wire bin_shutdown;
wire shutdown_cmd;

assign nmea_shutdown = cmd_valid & ~cmd_binary_mode &
    cmd_is_shutdown_sentence & nmea_off_ok &
    (cmd_param == `NMEA_SHUTDOWN_PARAM);
assign bin_shutdown = cmd_valid & cmd_binary_mode &
    (cmd_msg_id == `BIN_OFF_MSG_ID);
assign shutdown_cmd = nmea_shutdown | bin_shutdown;

// ==========================================================================
// Mode state machine
// ==========================================================================
reg [2:0] state_q;
reg [2:0] state_d;
reg [39:0] cnt_q;
reg [39:0] cnt_d;
reg refresh_d;
reg accept_d;

always @*
begin
    state_d = state_q;
    cnt_d = cnt_q;
    refresh_d = 1'b0;
    accept_d = 1'b0;
    case (state_q)
        ST_RUN:
        begin
            // Command wins over a toggle edge in the same cycle
            if (shutdown_cmd)
            begin
                state_d = ST_WIND_DOWN;
                cnt_d = WIND_DOWN_CYCLES;
                accept_d = 1'b1;
            end
            else if (toggle_rise && toggle_hib_ok)
            begin
                state_d = ST_HIBERNATE;
            end
            else if (ptf_enable && fix_done)
            begin
                state_d = ST_PTF_SLEEP;
                cnt_d = PTF_SLEEP_CYCLES;
            end
        end
        ST_PTF_SLEEP:
        begin
            // Extra fix on demand, or the periodic refresh
            if (toggle_rise)
            begin
                state_d = ST_RUN;
                refresh_d = 1'b1;
            end
            else if (cnt_q <= `CNT_ONE)
            begin
                state_d = ST_RUN;
                refresh_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q - `CNT_ONE;
            end
        end
        ST_HIBERNATE:
        begin
            if (toggle_rise)
            begin
                state_d = ST_RUN;
            end
        end
        ST_WIND_DOWN:
        begin
            // Kept short so the indicator falls well inside the host hold
            if (cnt_q <= `CNT_ONE)
            begin
                state_d = ST_OFF;
                cnt_d = `CNT_ZERO;
            end
            else
            begin
                cnt_d = cnt_q - `CNT_ONE;
            end
        end
        ST_OFF:
        begin
            // Only a supply cycle, seen as reset, leaves this state
            state_d = ST_OFF;
        end
        default:
        begin
            state_d = ST_RUN;
            cnt_d = `CNT_ZERO;
        end
    endcase
end

always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        state_q <= ST_RUN;
        cnt_q <= `CNT_ZERO;
    end
    else
    begin
        state_q <= state_d;
        cnt_q <= cnt_d;
    end
end

// ==========================================================================
// Registered outputs, derived from the next state
// ==========================================================================
always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        rf_power_up_indicator <= 1'b0;
        core_power_en <= 1'b0;
        refresh_req <= 1'b0;
        rtc_run <= 1'b0;
        sram_retain <= 1'b0;
        backup_supply_select <= 1'b0;
        cmd_accept <= 1'b0;
        mode <= ST_RUN;
    end
    else
    begin
        // RF stays up through wind-down; its fall tells the host it may cut
        rf_power_up_indicator <= (state_d == ST_RUN) ||
            (state_d == ST_WIND_DOWN);
        core_power_en <= (state_d == ST_RUN) ||
            (state_d == ST_WIND_DOWN);
        refresh_req <= refresh_d;
        // Clock and memory are kept in every low-power state
        rtc_run <= 1'b1;
        sram_retain <= (state_d != ST_RUN) &&
            (state_d != ST_WIND_DOWN);
        backup_supply_select <= (state_d == ST_OFF);
        cmd_accept <= accept_d;
        mode <= state_d;
    end
end

endmodule // power_mode_ctrl

/* File: testbench/power_mode_checker_assertions.sv */
`timescale 1ns/1ps
// ==========================================================================
// Power-mode checker
// ==========================================================================
module power_mode_checker
(
    input logic mclk,
    input logic rst,
    input logic power_toggle,
    input logic cmd_valid,
    input logic cmd_binary_mode,
    input logic cmd_is_shutdown_sentence,
    input logic [7:0] cmd_msg_id,
    input logic [7:0] cmd_param,
    input logic rf_power_up_indicator,
    input logic refresh_req,
    input logic rtc_run,
    input logic sram_retain,
    input logic backup_supply_select,
    input logic cmd_accept,
    input logic [2:0] mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    AST_BIN_OFF: assert property (
        cmd_valid && cmd_binary_mode && cmd_msg_id == 8'hCD && mode == 3'h0
        |=> cmd_accept && mode == 3'h3) else $error("binary off missed");
    AST_TEXT_OFF: assert property (
        cmd_valid && !cmd_binary_mode && cmd_is_shutdown_sentence &&
        cmd_param == 8'h10 && mode == 3'h0 |=> cmd_accept && mode == 3'h3)
        else $error("text shutdown missed");
    AST_WIND_DOWN: assert property (
        mode == 3'h3 |-> rf_power_up_indicator ##1 mode inside {3'h3, 3'h4})
        else $error("wind-down left wrongly");
    AST_OFF_STATE: assert property (
        mode == 3'h4 |-> backup_supply_select && sram_retain && rtc_run &&
        !rf_power_up_indicator) else $error("off state not retained");
    AST_HIB_STATE: assert property (
        mode == 3'h2 |-> !rf_power_up_indicator && sram_retain && rtc_run)
        else $error("hibernate outputs wrong");
    AST_HIB_WAKE: assert property (
        $rose(power_toggle) && mode == 3'h2 |-> ##[3:7] mode == 3'h0)
        else $error("toggle did not wake");
    AST_REFRESH: assert property (
        refresh_req |-> mode == 3'h0 && $past(mode) == 3'h1)
        else $error("refresh without sleep");
endmodule // power_mode_checker

bind power_mode_ctrl power_mode_checker chk_u (.mclk(mclk), .rst(rst),
    .power_toggle(power_toggle), .cmd_valid(cmd_valid),
    .cmd_binary_mode(cmd_binary_mode),
    .cmd_is_shutdown_sentence(cmd_is_shutdown_sentence),
    .cmd_msg_id(cmd_msg_id), .cmd_param(cmd_param),
    .rf_power_up_indicator(rf_power_up_indicator),
    .refresh_req(refresh_req), .rtc_run(rtc_run),
    .sram_retain(sram_retain), .backup_supply_select(backup_supply_select),
    .cmd_accept(cmd_accept), .mode(mode));

/* File: testbench/host_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// Host controller model
// ==========================================================================
module host_model
#(
    parameter int PULSE = 6,
    parameter int SUPPLY_HOLD = 50
)
(
    input logic mclk,
    input logic rf_power_up_indicator,
    output logic power_toggle = 1'b0,
    output logic cmd_valid = 1'b0,
    output logic cmd_binary_mode = 1'b0,
    output logic cmd_is_shutdown_sentence = 1'b0,
    output logic [7:0] cmd_msg_id = 8'h00,
    output logic [7:0] cmd_param = 8'h00
);
    // Short high pulse stands in for the long one; low before next
    task toggle();
        @(posedge mclk);
        power_toggle <= 1'b1;
        repeat (PULSE) @(posedge mclk);
        power_toggle <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
    // Idle fields flip so stale values never look valid
    task send(input logic bin, input logic snt, input logic [7:0] id,
        input logic [7:0] prm);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_binary_mode <= bin;
        cmd_is_shutdown_sentence <= snt;
        {cmd_msg_id, cmd_param} <= {id, prm};
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_binary_mode <= ~bin;
        cmd_is_shutdown_sentence <= ~snt;
        {cmd_msg_id, cmd_param} <= {~id, ~prm};
    endtask
    // Supply stays on throughout; cut only after indicator low or timeout
    task supply_off_ok();
        int i;
        for (i = 0; i < SUPPLY_HOLD && rf_power_up_indicator; i++)
            @(posedge mclk);
    endtask
endmodule // host_model

/* File: testbench/power_mode_ctrl_test.sv */
`timescale 1ns/1ps
// ==========================================================================
// Power-mode controller testbench
// ==========================================================================
module power_mode_ctrl_test;
    localparam int PTF = 32'h14;
    localparam int WIND = 32'h8;
    // Sync, filter and edge stages between pin and state
    localparam int TOG = 5;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ptf_enable = 1'b0;
    logic fix_done = 1'b0;
    logic power_toggle, cmd_valid, cmd_binary_mode, cmd_is_shutdown_sentence;
    logic [7:0] cmd_msg_id, cmd_param;
    logic rf_power_up_indicator, core_power_en, refresh_req, rtc_run;
    logic sram_retain, backup_supply_select, cmd_accept;
    logic [2:0] mode;
    int err_count = 0;
    int check_count = 0;
    always #4 mclk = ~mclk;
    host_model host_u (.mclk(mclk),
        .rf_power_up_indicator(rf_power_up_indicator),
        .power_toggle(power_toggle), .cmd_valid(cmd_valid),
        .cmd_binary_mode(cmd_binary_mode),
        .cmd_is_shutdown_sentence(cmd_is_shutdown_sentence),
        .cmd_msg_id(cmd_msg_id), .cmd_param(cmd_param));
    power_mode_ctrl #(.PTF_SLEEP_CYCLES(40'h14), .WIND_DOWN_CYCLES(40'h8))
    dut_u (.mclk(mclk), .rst(rst), .power_toggle(power_toggle),
        .ptf_enable(ptf_enable), .fix_done(fix_done), .cmd_valid(cmd_valid),
        .cmd_binary_mode(cmd_binary_mode),
        .cmd_is_shutdown_sentence(cmd_is_shutdown_sentence),
        .cmd_msg_id(cmd_msg_id), .cmd_param(cmd_param),
        .rf_power_up_indicator(rf_power_up_indicator),
        .core_power_en(core_power_en), .refresh_req(refresh_req),
        .rtc_run(rtc_run), .sram_retain(sram_retain),
        .backup_supply_select(backup_supply_select),
        .cmd_accept(cmd_accept), .mode(mode));
    task tally_and_finish();
        if (err_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Counts edges until mode reaches m; a spent bound ends the run
    task count_to(input logic [2:0] m, output int n);
        for (n = 1; n < 64; n++)
        begin
            @(posedge mclk);
            #1;
            if (mode === m)
                return;
        end
        err_count++;
        tally_and_finish();
    endtask
    task do_reset();
        rst <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1 chk(rtc_run, 1'b1);
        chk(core_power_en, 1'b1);
    endtask
    task t_ptf();
        int n;
        @(posedge mclk);
        {ptf_enable, fix_done} <= 2'h3;
        @(posedge mclk);
        fix_done <= 1'b0;
        #1 chk(mode, 3'h1);
        chk(sram_retain, 1'b1);
        count_to(3'h0, n);
        chk(8'(n), 8'(PTF));
        chk(refresh_req, 1'b1);
        ptf_enable <= 1'b0;
    endtask
    task t_ptf_wake();
        int n;
        @(posedge mclk);
        {ptf_enable, fix_done} <= 2'h3;
        @(posedge mclk);
        {ptf_enable, fix_done} <= 2'h0;
        #1 chk(mode, 3'h1);
        fork
            host_u.toggle();
            begin
                count_to(3'h0, n);
                chk(refresh_req, 1'b1);
                chk(8'(n), 8'(TOG + 1));
            end
        join
    endtask
    task t_toggle();
        host_u.toggle();
        #1 chk(mode, 3'h2);
        chk(rf_power_up_indicator, 1'b0);
        chk(core_power_en, 1'b0);
        host_u.send(1'b1, 1'b0, 8'hCD, 8'h00);
        #1 chk(cmd_accept, 1'b0);
        chk(mode, 3'h2);
        host_u.toggle();
        #1 chk(mode, 3'h0);
        chk(rf_power_up_indicator, 1'b1);
    endtask
    task t_refuse();
        host_u.send(1'b0, 1'b1, 8'h00, 8'h0F);
        #1 chk(cmd_accept, 1'b0);
        host_u.send(1'b0, 1'b0, 8'h00, 8'h10);
        #1 chk(cmd_accept, 1'b0);
        host_u.send(1'b1, 1'b0, 8'hCC, 8'h10);
        #1 chk(cmd_accept, 1'b0);
    endtask
    task t_off(input logic bin);
        int n;
        host_u.send(bin, ~bin, bin ? 8'hCD : 8'h00, bin ? 8'h00 : 8'h10);
        #1 chk(cmd_accept, 1'b1);
        chk(mode, 3'h3);
        count_to(3'h4, n);
        chk(8'(n), 8'(WIND));
        chk({core_power_en, backup_supply_select, sram_retain, rtc_run},
            4'h7);
        host_u.supply_off_ok();
        chk(rf_power_up_indicator, 1'b0);
        host_u.toggle();
        #1 chk(mode, 3'h4);
    endtask
    initial
    begin
        do_reset();
        t_ptf();
        t_ptf_wake();
        t_toggle();
        t_refuse();
        t_off(1'b0);
        @(posedge mclk);
        do_reset();
        t_off(1'b1);
        tally_and_finish();
    end
endmodule // power_mode_ctrl_test
